// [pit_decoder.sv]
`timescale 1ns/1ps
`include "pit_defines.svh"
// Overview of operation
// - Opcodes decode with standard encoding, addressing and flag effects.
// - Durations counted in single core clocks, no machine cycles.
// - Most instructions take as many clocks as they have bytes.
// - Failed conditional branch finishes two to four clocks sooner than taken.
// - Register arithmetic takes 1 clock, indirect RAM arithmetic 2.
// - Code byte load via data pointer takes 3 slow, 6 fast.
// - Every external data move takes 3 clocks in both columns.
// - Immediate data pointer load is three bytes, three clocks.
// - Low nibble exchange is one byte, two clocks.
// - Jump on carry set: 2 not taken, 4 slow or 6 fast taken.
// - Jump on carry clear: 2 not taken, 4 slow or 5 fast taken.
// - Jump bit set and clear: 3, or 5 slow / 7 fast; clears bit.
// - Compare jump unequal direct: 4, or 6 slow / 7 fast.
// - Decrement jump nonzero direct: 3, or 5 slow / 7 fast.
// - Short relative jump takes 4 slow, 6 fast.
// - Indirect jump via accumulator plus data pointer: 3 slow, 5 fast.
// - Relative target is next instruction address plus signed 8-bit offset.
// - Page jumps replace only low 11 bits, staying in the 2 KB page.
// - Long call and jump carry a full 16-bit target.
// - Direct address below 0x80 is RAM, above is special registers.
// - Register operands use current bank; indirect uses first two registers.
// - Unassigned opcode 0xA5 behaves exactly like no operation.
// - Bank select maps working registers to one of four 8-byte RAM blocks.
// - Stack pointer increments before each push and resets to 0x07.
// - After a branch the core stalls at most two clocks for code.
module pit_decoder
  import pit_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Instruction request
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [15:0] next_pc_i,
  input wire logic cond_i,
  // Core state used for addressing
  input wire logic [1:0] bank_select_i,
  input wire logic [7:0] ptr_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_i,
  // Timing configuration and prefetch handshake
  input wire logic flash_read_timing_sel_i,
  input wire logic code_ready_i,
  // Results
  output logic busy_o,
  output logic done_o,
  output logic stall_o,
  output logic taken_o,
  output logic [1:0] len_o,
  output logic [3:0] cycles_o,
  output logic target_valid_o,
  output logic [15:0] target_o,
  output logic [7:0] oper_addr_o,
  output logic oper_sfr_o,
  output logic [2:0] flag_mask_o,
  output logic [7:0] sp_o
);

  // ***********************************************************************
  // Opcode table
  // ***********************************************************************
  // Fill length and both timing columns; a nonzero taken count marks a
  // conditional branch
  function automatic pit_info_t put(input pit_info_t b, input logic [1:0] l,
                                    input logic [3:0] s, input logic [3:0] f,
                                    input logic [3:0] t, input logic [3:0] u);
    pit_info_t r;
    r = b;
    r.len = l;
    r.cs = s;
    r.cf = f;
    r.ts = t;
    r.tf = u;
    r.cond = (t != 4'h0);
    r.jtype = (t != 4'h0) ? JT_REL : b.jtype;
    return r;
  endfunction

  // Default one byte, one clock; exceptions below in priority order
  function automatic pit_info_t decode(input logic [7:0] op);
    pit_info_t i;
    i = '{len: 2'h1, cs: 4'h1, cf: 4'h1, ts: 4'h0, tf: 4'h0, cond: 1'b0,
          amode: AM_NONE, jtype: JT_NONE, fmask: `PIT_FM_NONE, sp_step: 3'sh0};
    // Operand field in the low nibble
    if (op[3]) begin
      i.amode = AM_REG;
    end else if (op[3:1] == 3'h3) begin
      i.amode = AM_IND;
      i = put(i, 2'h1, 4'h2, 4'h2, 4'h0, 4'h0);
    end else if (op[3:0] == 4'h5 && op != `PIT_NOP_ALT) begin
      i.amode = AM_DIR;
      i = put(i, 2'h2, 4'h2, 4'h2, 4'h0, 4'h0);
    end
    casez (op)
      8'b????_0001: begin
        i = put(i, 2'h2, 4'h4, 4'h6, 4'h0, 4'h0);
        i.jtype = JT_PAGE;
        i.sp_step = op[4] ? 3'sh2 : 3'sh0;
      end
      8'h02: begin
        i = put(i, 2'h3, 4'h4, 4'h6, 4'h0, 4'h0);
        i.jtype = JT_FULL;
      end
      8'h12: begin
        i = put(i, 2'h3, 4'h5, 4'h7, 4'h0, 4'h0);
        i.jtype = JT_FULL;
        i.sp_step = 3'sh2;
      end
      8'h22, 8'h32: begin
        i = put(i, 2'h1, 4'h6, op[4] ? 4'h7 : 4'h8, 4'h0, 4'h0);
        i.jtype = JT_RET;
        i.sp_step = -3'sh2;
      end
      8'h10, 8'h20: i = put(i, 2'h3, 4'h3, 4'h3, 4'h5, 4'h7);
      8'h30: i = put(i, 2'h3, 4'h3, 4'h3, 4'h5, 4'h6);
      8'h40: begin
        i = put(i, 2'h2, 4'h2, 4'h2, 4'h4, 4'h6);
      end
      8'h50, 8'h60, 8'h70: i = put(i, 2'h2, 4'h2, 4'h2, 4'h4, 4'h5);
      8'h80: begin
        i = put(i, 2'h2, 4'h4, 4'h6, 4'h0, 4'h0);
        i.jtype = JT_REL;
      end
      8'h73: begin
        i = put(i, 2'h1, 4'h3, 4'h5, 4'h0, 4'h0);
        i.jtype = JT_IND;
      end
      8'hB5, 8'hB6, 8'hB7: begin
        i = put(i, 2'h3, 4'h4, 4'h4, 4'h6, 4'h7);
        i.fmask = `PIT_FM_CY;
      end
      8'hB4, 8'b1011_1???: begin
        i = put(i, 2'h3, 4'h3, 4'h3, 4'h5, 4'h6);
        i.fmask = `PIT_FM_CY;
      end
      8'hD5: i = put(i, 2'h3, 4'h3, 4'h3, 4'h5, 4'h7);
      8'b1101_1???: i = put(i, 2'h2, 4'h2, 4'h2, 4'h4, 4'h5);
      8'h90: i = put(i, 2'h3, 4'h3, 4'h3, 4'h0, 4'h0);
      8'h93: i = put(i, 2'h1, 4'h3, 4'h6, 4'h0, 4'h0);
      8'h83: i = put(i, 2'h1, 4'h3, 4'h3, 4'h0, 4'h0);
      8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: begin
        i = put(i, 2'h1, `PIT_CYC_EXT_MOVE, `PIT_CYC_EXT_MOVE, 4'h0, 4'h0);
      end
      8'hA4: begin
        i = put(i, 2'h1, 4'h4, 4'h4, 4'h0, 4'h0);
        i.fmask = `PIT_FM_CY_OV;
      end
      8'h84: begin
        i = put(i, 2'h1, 4'h8, 4'h8, 4'h0, 4'h0);
        i.fmask = `PIT_FM_CY_OV;
      end
      8'hD3: begin
        i = put(i, 2'h1, 4'h1, 4'h2, 4'h0, 4'h0);
        i.fmask = `PIT_FM_CY;
      end
      `PIT_NOP_ALT: i = put(i, 2'h1, 4'h1, 4'h1, 4'h0, 4'h0);
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin
        i = put(i, 2'h3, 4'h3, 4'h3, 4'h0, 4'h0);
        i.amode = AM_DIR;
      end
      8'b1000_011?, 8'b1010_011?, 8'b0111_011?, 8'b1000_1???, 8'b1010_1???,
      8'b0111_1???: i = put(i, 2'h2, 4'h2, 4'h2, 4'h0, 4'h0);
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94, 8'h72, 8'h82,
      8'h92, 8'hA2, 8'hB2, 8'hC2, 8'hD2, 8'hA0, 8'hB0: begin
        i = put(i, 2'h2, 4'h2, 4'h2, 4'h0, 4'h0);
      end
      8'h42, 8'h52, 8'h62, 8'hC0, 8'hD0: begin
        i = put(i, 2'h2, 4'h2, 4'h2, 4'h0, 4'h0);
        i.amode = AM_DIR;
        i.sp_step = (op == 8'hC0) ? 3'sh1 : (op == 8'hD0) ? -3'sh1 : 3'sh0;
      end
      default: ;
    endcase
    // Flag effects of the arithmetic and carry-bit groups
    if (op[7:5] == 3'h1 || op[7:4] == 4'h9) begin
      if (op[3:2] != 2'h0 || op[1:0] == 2'h0 && op[2]) begin
        i.fmask = `PIT_FM_ALL;
      end
    end
    if (op == 8'h13 || op == 8'h33 || op == 8'hD4 || op == 8'hB3 || op == 8'hC3 ||
        op == 8'h72 || op == 8'h82 || op == 8'hA0 || op == 8'hB0 || op == 8'hA2) begin
      i.fmask = `PIT_FM_CY;
    end
    return i;
  endfunction

  // ***********************************************************************
  // Decode of the offered instruction
  // ***********************************************************************
  // State register, declared here because the decode reads the idle state
  pit_reg_t r_q;
  pit_reg_t r_d;
  pit_info_t inf;
  logic [3:0] cyc;
  logic [7:0] rel;
  logic [15:0] tgt;
  logic [7:0] oaddr;
  logic accept;

  // Timing column and condition choose the clock count
  always_comb begin
    inf = decode(opcode_i);
    accept = start_i && (r_q.st == ST_IDLE);
    if (inf.cond && cond_i) begin
      cyc = flash_read_timing_sel_i ? inf.tf : inf.ts;
    end else begin
      cyc = flash_read_timing_sel_i ? inf.cf : inf.cs;
    end
    // Offset sits in the last byte of the instruction
    rel = (inf.len == 2'h3) ? operand2_i : operand1_i;
    unique case (inf.jtype)
      JT_REL: tgt = next_pc_i + {{8{rel[7]}}, rel};
      JT_PAGE: tgt = {next_pc_i[15:`PIT_PAGE_LSB], opcode_i[7:5], operand1_i};
      JT_FULL: tgt = {operand1_i, operand2_i};
      JT_IND: tgt = data_pointer_i + {8'h00, acc_i};
      default: tgt = 16'h0000;
    endcase
    unique case (inf.amode)
      AM_REG: oaddr = {3'h0, bank_select_i, opcode_i[2:0]};
      AM_IND: oaddr = ptr_i;
      AM_DIR: oaddr = operand1_i;
      default: oaddr = 8'h00;
    endcase
  end

  // ***********************************************************************
  // Sequencer
  // ***********************************************************************
  // Count the clocks of one instruction, then hold for fetch after a branch
  always_comb begin
    r_d = r_q;
    r_d.o.done = 1'b0;
    unique case (r_q.st)
      ST_IDLE: begin
        if (accept) begin
          r_d.o.len = inf.len;
          r_d.o.cycles = cyc;
          r_d.o.taken = (inf.cond && cond_i) || (!inf.cond && inf.jtype != JT_NONE);
          r_d.o.tvalid = (inf.jtype != JT_NONE) && (inf.jtype != JT_RET);
          r_d.o.target = tgt;
          r_d.o.oper_addr = oaddr;
          r_d.o.oper_sfr = (inf.amode == AM_DIR) && oaddr[`PIT_SFR_BIT];
          r_d.o.fmask = inf.fmask;
          // Stack pointer moves up before a push writes
          r_d.sp = r_q.sp + 8'(signed'(inf.sp_step));
          r_d.jmp = r_d.o.taken;
          r_d.scnt = 2'h0;
          if (cyc == `PIT_CYC_ONE) begin
            r_d.o.done = 1'b1;
            r_d.st = r_d.jmp ? ST_STALL : ST_IDLE;
          end else begin
            r_d.cnt = cyc - 4'h2;
            r_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (r_q.cnt == 4'h0) begin
          r_d.o.done = 1'b1;
          r_d.st = r_q.jmp ? ST_STALL : ST_IDLE;
        end else begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      ST_STALL: begin
        // Give up waiting after the bound so a lost ready cannot hang the core
        if (code_ready_i || r_q.scnt == `PIT_STALL_MAX - 2'h1) begin
          r_d.st = ST_IDLE;
        end else begin
          r_d.scnt = r_q.scnt + 2'h1;
        end
      end
    endcase
    r_d.o.busy = (r_d.st != ST_IDLE);
    r_d.o.stall = (r_d.st == ST_STALL);
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_q <= '0;
      r_q.sp <= `PIT_SP_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign busy_o = r_q.o.busy;
  assign done_o = r_q.o.done;
  assign stall_o = r_q.o.stall;
  assign taken_o = r_q.o.taken;
  assign len_o = r_q.o.len;
  assign cycles_o = r_q.o.cycles;
  assign target_valid_o = r_q.o.tvalid;
  assign target_o = r_q.o.target;
  assign oper_addr_o = r_q.o.oper_addr;
  assign oper_sfr_o = r_q.o.oper_sfr;
  assign flag_mask_o = r_q.o.fmask;
  assign sp_o = r_q.sp;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  property p_reg_one;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'h28 |-> ##1 cycles_o == 4'h1 && done_o;
  endproperty
  a_reg_one: assert property (p_reg_one) else $error("register add not one clock");

  property p_ind_two;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'hD6 |-> ##1 !done_o && len_o == 2'h1 ##1 done_o;
  endproperty
  a_ind_two: assert property (p_ind_two) else $error("nibble exchange not two clocks");

  property p_ldptr;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'h90 |-> ##1 !done_o ##1 !done_o ##1 done_o && len_o == 2'h3;
  endproperty
  a_ldptr: assert property (p_ldptr) else $error("pointer load not three clocks");

  property p_jc_fast;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'h40 && cond_i && flash_read_timing_sel_i |-> ##1 cycles_o == 4'h6;
  endproperty
  a_jc_fast: assert property (p_jc_fast) else $error("taken carry jump not six");

  property p_jnc;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'h50 |->
      ##1 cycles_o == ($past(cond_i) ? ($past(flash_read_timing_sel_i) ? 4'h5 : 4'h4) : 4'h2);
  endproperty
  a_jnc: assert property (p_jnc) else $error("no-carry jump count wrong");

  property p_code_load;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'h93 |->
      ##1 cycles_o == ($past(flash_read_timing_sel_i) ? 4'h6 : 4'h3);
  endproperty
  a_code_load: assert property (p_code_load) else $error("code byte load count wrong");

  property p_ext_move;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && (opcode_i[7:5] == 3'h7) && (opcode_i[3:0] == 4'h0 || opcode_i[3:1] == 3'h1)
      |-> ##1 cycles_o == `PIT_CYC_EXT_MOVE;
  endproperty
  a_ext_move: assert property (p_ext_move) else $error("external move not three");

  property p_nop;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == `PIT_NOP_ALT |-> ##1 done_o && len_o == 2'h1 && !taken_o;
  endproperty
  a_nop: assert property (p_nop) else $error("spare opcode not a no-op");

  property p_push;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'hC0 |-> ##1 sp_o == $past(sp_o) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not raise stack pointer");

  property p_page;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i[3:0] == 4'h1 |->
      ##1 target_o[15:11] == $past(next_pc_i[15:11]) && target_o[7:0] == $past(operand1_i);
  endproperty
  a_page: assert property (p_page) else $error("page target left its page");

  property p_stall;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(stall_o) |-> ##[1:2] !stall_o;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch stall longer than two");

  property p_sfr;
    @(posedge clk_i) disable iff (!rstn_i)
    accept && opcode_i == 8'hE5 |-> ##1 oper_sfr_o == $past(operand1_i[7]);
  endproperty
  a_sfr: assert property (p_sfr) else $error("direct space select wrong");

endmodule

// [pit_defines.svh]
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH

// ***********************************************************************
// Reset values, field positions and the spare opcode
// ***********************************************************************
`define PIT_SP_RESET 8'h07
`define PIT_SFR_BIT 7
`define PIT_PAGE_LSB 11
`define PIT_NOP_ALT 8'hA5

// ***********************************************************************
// Flag masks {carry, aux carry, overflow}
// ***********************************************************************
`define PIT_FM_NONE 3'h0
`define PIT_FM_CY 3'h4
`define PIT_FM_CY_OV 3'h5
`define PIT_FM_ALL 3'h7

// ***********************************************************************
// Timing counts
// ***********************************************************************
`define PIT_STALL_MAX 2'h2
`define PIT_CYC_EXT_MOVE 4'h3
`define PIT_CYC_ONE 4'h1

`endif

// [pit_pkg.sv]
package pit_pkg;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STALL} pit_state_t;

  typedef enum logic [1:0] {AM_NONE, AM_REG, AM_IND, AM_DIR} pit_amode_t;

  typedef enum logic [2:0] {JT_NONE, JT_REL, JT_PAGE, JT_FULL, JT_IND, JT_RET} pit_jtype_t;

  // Static properties of one opcode
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cs;
    logic [3:0] cf;
    logic [3:0] ts;
    logic [3:0] tf;
    logic cond;
    pit_amode_t amode;
    pit_jtype_t jtype;
    logic [2:0] fmask;
    logic signed [2:0] sp_step;
  } pit_info_t;

  // Registered result seen by the core
  typedef struct packed {
    logic busy;
    logic done;
    logic stall;
    logic taken;
    logic [1:0] len;
    logic [3:0] cycles;
    logic tvalid;
    logic [15:0] target;
    logic [7:0] oper_addr;
    logic oper_sfr;
    logic [2:0] fmask;
  } pit_out_t;

  // Whole state of the decoder
  typedef struct packed {
    pit_state_t st;
    logic [3:0] cnt;
    logic [1:0] scnt;
    logic jmp;
    logic [7:0] sp;
    pit_out_t o;
  } pit_reg_t;

endpackage

// [pit_flash_model.sv]
`timescale 1ns/1ps
// ***********************************************************************
// Prefetch engine stand-in on the code side of the decoder
// ***********************************************************************
module pit_flash_model (
  // Core side
  input wire logic stall_i,
  input wire logic slow_i,
  // Prefetch answer
  output logic code_ready_o
);
  // Prompt flash answers in the first stall cycle; slow flash never does,
  // so the core has to end the stall by its own bound
  // Prefetch is taken as always enabled, as software is meant to keep it
  assign code_ready_o = stall_i & ~slow_i;
endmodule

// [tb.sv]
`timescale 1ns/1ps
// ***********************************************************************
// Testbench for the instruction timing decoder
// ***********************************************************************
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start, cond, tsel, slow, ready;
  logic [7:0] opcode, oper1, oper2, ptr, acc, exp_sp;
  logic [1:0] bank;
  logic [15:0] npc, dp_val;
  logic busy_o, done_o, stall_o, taken_o, target_valid_o, oper_sfr_o;
  logic [1:0] len_o;
  logic [3:0] cycles_o;
  logic [15:0] target_o;
  logic [7:0] oper_addr_o, sp_o;
  logic [2:0] flag_mask_o;
  int failures = 0;
  int n_compared = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  pit_decoder u_pit_decoder (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start), .opcode_i(opcode),
    .operand1_i(oper1), .operand2_i(oper2), .next_pc_i(npc), .cond_i(cond),
    .bank_select_i(bank), .ptr_i(ptr), .acc_i(acc), .data_pointer_i(dp_val),
    .flash_read_timing_sel_i(tsel), .code_ready_i(ready), .busy_o(busy_o),
    .done_o(done_o), .stall_o(stall_o), .taken_o(taken_o), .len_o(len_o),
    .cycles_o(cycles_o), .target_valid_o(target_valid_o), .target_o(target_o),
    .oper_addr_o(oper_addr_o), .oper_sfr_o(oper_sfr_o),
    .flag_mask_o(flag_mask_o), .sp_o(sp_o)
  );

  pit_flash_model u_pit_flash_model (
    .stall_i(stall_o), .slow_i(slow), .code_ready_o(ready)
  );

  // ***********************************************************************
  // Reporting
  // ***********************************************************************
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      failures++;
    end
  endtask

  // A wait that ran out of its bound ends the run
  task automatic give_up(input string what);
    $display("wrong value %s expected end of wait seen timeout", what);
    failures++;
    finish_test();
  endtask

  // ***********************************************************************
  // One instruction: offer it, count clocks to done, then sit out any stall
  // ***********************************************************************
  task automatic exec(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
                      input logic c, input logic [1:0] el, input logic [3:0] ec,
                      input logic et);
    int n;
    int ns;
    opcode = op;
    oper1 = o1;
    oper2 = o2;
    cond = c;
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    n = 1;
    while (done_o !== 1'b1) begin
      chk("busy", 16'h1, {15'h0, busy_o});
      if (n >= 9) give_up("done");
      @(negedge clk_i);
      n++;
    end
    chk("clocks", {12'h0, ec}, 16'(n));
    chk("cycles", {12'h0, ec}, {12'h0, cycles_o});
    chk("len", {14'h0, el}, {14'h0, len_o});
    chk("taken", {15'h0, et}, {15'h0, taken_o});
    // Stall may never exceed two clocks, whatever the flash does
    ns = 0;
    while (stall_o === 1'b1) begin
      if (ns >= 2) give_up("stall");
      @(negedge clk_i);
      ns++;
    end
    chk("stalled", {15'h0, et}, {15'h0, ns != 0});
  endtask

  task automatic tgt(input logic [15:0] e);
    chk("target valid", 16'h1, {15'h0, target_valid_o});
    chk("target", e, target_o);
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic t_reset();
    @(negedge clk_i);
    exp_sp = 8'h07;
    chk("sp", {8'h0, exp_sp}, {8'h0, sp_o});
    chk("busy", 16'h0, {15'h0, busy_o});
    $display("reset test done");
  endtask

  // Straight-line instructions, issued back to back in both timing columns
  task automatic t_timing();
    logic [7:0] xm [4] = '{8'hE0, 8'hF0, 8'hE2, 8'hF3};
    for (int f = 0; f < 2; f++) begin
      tsel = f[0];
      exec(8'h28, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 1'b0);
      chk("flags", 16'h7, {13'h0, flag_mask_o});
      exec(8'h26, 8'h00, 8'h00, 1'b0, 2'h1, 4'h2, 1'b0);
      exec(8'h53, 8'h30, 8'h0F, 1'b0, 2'h3, 4'h3, 1'b0);
      exec(8'h93, 8'h00, 8'h00, 1'b0, 2'h1, f ? 4'h6 : 4'h3, 1'b0);
      foreach (xm[i]) begin
        exec(xm[i], 8'h00, 8'h00, 1'b0, 2'h1, 4'h3, 1'b0);
      end
      exec(8'h90, 8'h12, 8'h34, 1'b0, 2'h3, 4'h3, 1'b0);
      exec(8'hD6, 8'h00, 8'h00, 1'b0, 2'h1, 4'h2, 1'b0);
      exec(8'hA5, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 1'b0);
      chk("flags", 16'h0, {13'h0, flag_mask_o});
      exec(8'h84, 8'h00, 8'h00, 1'b0, 2'h1, 4'h8, 1'b0);
      chk("flags", 16'h5, {13'h0, flag_mask_o});
    end
    $display("timing test done");
  endtask

  // Conditional branches, taken with slow flash and not taken with prompt flash
  task automatic t_cond();
    logic [7:0] op [5] = '{8'h40, 8'h50, 8'h10, 8'hB5, 8'hD5};
    logic [1:0] ln [5] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [3:0] nt [5] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h3};
    logic [3:0] ts [5] = '{4'h4, 4'h4, 4'h5, 4'h6, 4'h5};
    logic [3:0] tf [5] = '{4'h6, 4'h5, 4'h7, 4'h7, 4'h7};
    npc = 16'h1234;
    for (int k = 0; k < 20; k++) begin
      tsel = k[1];
      slow = k[0];
      exec(op[k / 4], ln[k / 4] == 2'h2 ? 8'h80 : 8'h30, 8'h80, k[0], ln[k / 4],
           k[0] ? (k[1] ? tf[k / 4] : ts[k / 4]) : nt[k / 4], k[0]);
      if (k[0]) tgt(16'h11B4);
    end
    $display("conditional test done");
  endtask

  // Unconditional flow changes and stack pointer steps
  task automatic t_jumps();
    for (int f = 0; f < 2; f++) begin
      tsel = f[0];
      slow = ~f[0];
      npc = 16'h1234;
      exec(8'h80, 8'h7F, 8'h00, 1'b0, 2'h2, f ? 4'h6 : 4'h4, 1'b1);
      tgt(16'h12B3);
      acc = 8'hF0;
      dp_val = 16'h1F20;
      exec(8'h73, 8'h00, 8'h00, 1'b0, 2'h1, f ? 4'h5 : 4'h3, 1'b1);
      tgt(16'h2010);
      npc = 16'h3FFE;
      exec(8'hE1, 8'h55, 8'h00, 1'b0, 2'h2, f ? 4'h6 : 4'h4, 1'b1);
      tgt(16'h3F55);
      exec(8'h02, 8'h1A, 8'hBC, 1'b0, 2'h3, f ? 4'h6 : 4'h4, 1'b1);
      tgt(16'h1ABC);
      exec(8'h12, 8'h1A, 8'hBC, 1'b0, 2'h3, f ? 4'h7 : 4'h5, 1'b1);
      exp_sp = exp_sp + 8'h02;
      chk("sp", {8'h0, exp_sp}, {8'h0, sp_o});
      // Return: a flow change with no decoded target, stack drops by two
      exec(8'h22, 8'h00, 8'h00, 1'b0, 2'h1, f ? 4'h8 : 4'h6, 1'b1);
      chk("target valid", 16'h0, {15'h0, target_valid_o});
      exp_sp = exp_sp - 8'h02;
      chk("sp", {8'h0, exp_sp}, {8'h0, sp_o});
      exec(8'hC0, 8'h30, 8'h00, 1'b0, 2'h2, 4'h2, 1'b0);
      exp_sp = exp_sp + 8'h01;
      chk("sp", {8'h0, exp_sp}, {8'h0, sp_o});
      exec(8'hD0, 8'h30, 8'h00, 1'b0, 2'h2, 4'h2, 1'b0);
      exp_sp = exp_sp - 8'h01;
      chk("sp", {8'h0, exp_sp}, {8'h0, sp_o});
    end
    $display("jump test done");
  endtask

  // Operand address forms
  task automatic t_operands();
    tsel = 1'b0;
    exec(8'hE5, 8'h7F, 8'h00, 1'b0, 2'h2, 4'h2, 1'b0);
    chk("addr", 16'h7F, {8'h0, oper_addr_o});
    chk("sfr", 16'h0, {15'h0, oper_sfr_o});
    exec(8'hE5, 8'h80, 8'h00, 1'b0, 2'h2, 4'h2, 1'b0);
    chk("sfr", 16'h1, {15'h0, oper_sfr_o});
    for (int b = 0; b < 4; b++) begin
      bank = b[1:0];
      exec(8'h2D, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 1'b0);
      chk("addr", {11'h0, b[1:0], 3'h5}, {8'h0, oper_addr_o});
    end
    ptr = 8'h5A;
    exec(8'h27, 8'h00, 8'h00, 1'b0, 2'h1, 4'h2, 1'b0);
    chk("addr", 16'h5A, {8'h0, oper_addr_o});
    $display("operand test done");
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    start = 1'b0;
    cond = 1'b0;
    tsel = 1'b0;
    slow = 1'b0;
    opcode = 8'h00;
    oper1 = 8'h00;
    oper2 = 8'h00;
    ptr = 8'h00;
    acc = 8'h00;
    bank = 2'h0;
    npc = 16'h0000;
    dp_val = 16'h0000;
    exp_sp = 8'h07;
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    t_reset();
    t_timing();
    t_cond();
    t_jumps();
    t_operands();
    finish_test();
  end
endmodule
